/* File: sfl_defs.vh */
// Constants for the serial flash latch, status and boot command logic
`ifndef SFL_DEFS_VH
`define SFL_DEFS_VH

// Opcodes
`define SFL_OP_LATCH_SET 8'h06
`define SFL_OP_LATCH_CLR 8'h04
`define SFL_OP_FLAG_CLR 8'h30
`define SFL_OP_ECC_RD 8'h18
`define SFL_OP_BCFG_RD 8'h14
`define SFL_OP_BCFG_WR 8'h15
`define SFL_OP_PAT_NV 8'h43
`define SFL_OP_PAT_VOL 8'h4a
`define SFL_OP_PAT_RD 8'h41

// Bit counts of a frame
`define SFL_BITS_OPC 6'h08
`define SFL_BITS_BYTE 6'h10
`define SFL_BITS_WORD 6'h28
`define SFL_BITS_MAX 6'h3f

// Boot configuration fields
`define SFL_BC_EN 0
`define SFL_BC_DLY_LO 1
`define SFL_BC_DLY_HI 8
`define SFL_BC_SA_LO 9
`define SFL_BC_SA_HI 31
`define SFL_BC_SA_PAD 9'h000

// ECC unit handling
`define SFL_ECC_LAST 4'hf
`define SFL_ECC_MASK 32'hfffffff0
`define SFL_ECC_STEP 32'h00000010

// Output lane enables, low drives
`define SFL_OE_NONE 4'hf
`define SFL_OE_SER 4'hd
`define SFL_OE_QUAD 4'h0

`endif

/* File: sfl_sync.v */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sfl_sync #(
    parameter W = 3,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire core_clk,
    input wire nrst,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_q;

    // ***************************
    // Two stage capture
    // ***************************
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // sfl_sync
`default_nettype wire

/* File: sfl_cmd.v */
// Serial flash latch, status, ECC status, boot read and pattern commands
`timescale 1ns/10ps
`default_nettype none
`include "sfl_defs.vh"
module sfl_cmd #(
    parameter NV_WRITE_CYCLES = 1000,
    parameter [31:0] BOOT_CFG_INIT = 32'h00000000,
    parameter [7:0] PATTERN_INIT = 8'h00
) (
    input wire core_clk,
    input wire nrst,
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire quad_mode,
    input wire [3:0] read_latency,
    input wire [7:0] ecc_unit_status,
    input wire [7:0] rd_data,
    input wire nv_erase_fail,
    input wire nv_prog_fail,
    output reg [3:0] dq_out_q,
    output reg [3:0] dq_oe_n_q,
    output reg [31:0] rd_addr_q,
    output reg write_permit_latch_q,
    output reg busy_flag_q,
    output reg erase_fail_q,
    output reg program_fail_q,
    output reg [31:0] boot_cfg_q,
    output reg [7:0] learning_pattern_q
);
    // One-hot frame states
    localparam [6:0] S_OPC = 7'h01;
    localparam [6:0] S_ADDR = 7'h02;
    localparam [6:0] S_DUMMY = 7'h04;
    localparam [6:0] S_RX = 7'h08;
    localparam [6:0] S_TX = 7'h10;
    localparam [6:0] S_SKIP = 7'h20;
    localparam [6:0] S_BDLY = 7'h40;

    // Output sources
    localparam [3:0] SRC_ECC = 4'h1;
    localparam [3:0] SRC_BCFG = 4'h2;
    localparam [3:0] SRC_PAT = 4'h4;
    localparam [3:0] SRC_BOOT = 4'h8;

    localparam [15:0] NV_CYC = NV_WRITE_CYCLES[15:0];

    // ***************************
    // Pin synchronisation
    // ***************************
    wire [2:0] pin_s;
    wire cs_s;
    wire sck_s;
    wire si_s;

    sfl_sync #(.W(3), .INIT(3'b100)) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .d({cs_n, sck, si}),
        .q(pin_s)
    );

    assign cs_s = pin_s[2];
    assign sck_s = pin_s[1];
    assign si_s = pin_s[0];

    reg cs_d_q;
    reg sck_d_q;

    // Edge history of synchronised pins
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cs_d_q <= 1'b1;
            sck_d_q <= 1'b0;
        end else begin
            cs_d_q <= cs_s;
            sck_d_q <= sck_s;
        end
    end

    wire cs_fall = ~cs_s & cs_d_q;
    wire cs_rise = cs_s & ~cs_d_q;
    wire sck_rise = sck_s & ~sck_d_q & ~cs_s;
    wire sck_fall = ~sck_s & sck_d_q & ~cs_s;

    // ***************************
    // Frame state
    // ***************************
    reg [6:0] state_q;
    reg [31:0] sh_q;
    reg [5:0] bits_q;
    reg [7:0] opc_q;
    reg [7:0] dcnt_q;
    reg [3:0] src_q;
    reg [3:0] rep_q;
    reg [7:0] tx_sh_q;
    reg [2:0] tx_cnt_q;
    reg quad_q;
    reg boot_pend_q;
    reg [7:0] pattern_nv_register_q;
    reg op_run_q;

    wire [7:0] boot_dly = boot_cfg_q[`SFL_BC_DLY_HI:`SFL_BC_DLY_LO];
    wire boot_go = cs_fall & boot_pend_q & boot_cfg_q[`SFL_BC_EN];
    wire boot_now = boot_go & (boot_dly == 8'h00);
    wire [7:0] opc_next = {sh_q[6:0], si_s};
    wire [31:0] addr_next = {sh_q[30:0], si_s};
    wire boot_quad = quad_mode;

    // Byte to be sent next
    reg [7:0] nb;
    always @* begin
        case (src_q)
            SRC_ECC: nb = ecc_unit_status;
            SRC_BCFG: begin
                case (rep_q[1:0])
                    2'h0: nb = boot_cfg_q[7:0];
                    2'h1: nb = boot_cfg_q[15:8];
                    2'h2: nb = boot_cfg_q[23:16];
                    default: nb = boot_cfg_q[31:24];
                endcase
            end
            SRC_PAT: nb = learning_pattern_q;
            SRC_BOOT: nb = rd_data;
            default: nb = 8'h00;
        endcase
    end

    wire tx_load = (sck_fall & (state_q == S_TX) & (tx_cnt_q == 3'h0)) | boot_now;
    wire tx_shift = sck_fall & (state_q == S_TX) & (tx_cnt_q != 3'h0);

    // Command sequencing on the serial clock edges
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= S_OPC;
            sh_q <= 32'h00000000;
            bits_q <= 6'h00;
            opc_q <= 8'h00;
            dcnt_q <= 8'h00;
            src_q <= 4'h0;
            boot_pend_q <= 1'b1;
        end else if (cs_s) begin
            // Select high ends any frame, boot included
            state_q <= S_OPC;
            bits_q <= 6'h00;
        end else if (cs_fall) begin
            bits_q <= 6'h00;
            opc_q <= 8'h00;
            boot_pend_q <= 1'b0;
            if (boot_go) begin
                src_q <= SRC_BOOT;
                dcnt_q <= boot_dly;
                state_q <= boot_now ? S_TX : S_BDLY;
            end else begin
                src_q <= 4'h0;
                state_q <= S_OPC;
            end
        end else if (sck_rise) begin
            sh_q <= addr_next;
            if (bits_q != `SFL_BITS_MAX) begin
                bits_q <= bits_q + 6'h01;
            end
            case (state_q)
                S_OPC: begin
                    if (bits_q == `SFL_BITS_OPC - 6'h01) begin
                        opc_q <= opc_next;
                        if (opc_next == `SFL_OP_ECC_RD) begin
                            src_q <= SRC_ECC;
                            state_q <= S_ADDR;
                        end else if (opc_next == `SFL_OP_BCFG_RD) begin
                            src_q <= SRC_BCFG;
                            state_q <= S_TX;
                        end else if (opc_next == `SFL_OP_PAT_RD) begin
                            src_q <= SRC_PAT;
                            state_q <= S_TX;
                        end else if (opc_next == `SFL_OP_BCFG_WR ||
                                     opc_next == `SFL_OP_PAT_NV ||
                                     opc_next == `SFL_OP_PAT_VOL) begin
                            state_q <= S_RX;
                        end else begin
                            state_q <= S_SKIP;
                        end
                    end
                end
                S_ADDR: begin
                    if (bits_q == `SFL_BITS_WORD - 6'h01) begin
                        dcnt_q <= {4'h0, read_latency};
                        state_q <= (read_latency == 4'h0) ? S_TX : S_DUMMY;
                    end
                end
                S_DUMMY, S_BDLY: begin
                    dcnt_q <= dcnt_q - 8'h01;
                    if (dcnt_q == 8'h01) begin
                        state_q <= S_TX;
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // ***************************
    // Output shifter
    // ***************************
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_sh_q <= 8'h00;
            tx_cnt_q <= 3'h0;
            quad_q <= 1'b0;
            rep_q <= 4'h0;
            rd_addr_q <= 32'h00000000;
            dq_out_q <= 4'h0;
            dq_oe_n_q <= `SFL_OE_NONE;
        end else if (cs_s) begin
            tx_cnt_q <= 3'h0;
            rep_q <= 4'h0;
            dq_oe_n_q <= `SFL_OE_NONE;
        end else if (cs_fall) begin
            tx_cnt_q <= 3'h0;
            rep_q <= 4'h0;
            quad_q <= boot_go & boot_quad;
            // Boot address is the 512 byte aligned start field
            rd_addr_q <= {boot_cfg_q[`SFL_BC_SA_HI:`SFL_BC_SA_LO], `SFL_BC_SA_PAD};
            if (boot_now) begin
                // Zero delay: first bits must stand before the first rise
                dq_out_q <= boot_quad ? rd_data[7:4] : {2'b00, rd_data[7], 1'b0};
                dq_oe_n_q <= boot_quad ? `SFL_OE_QUAD : `SFL_OE_SER;
                tx_sh_q <= boot_quad ? {rd_data[3:0], 4'h0} : {rd_data[6:0], 1'b0};
                tx_cnt_q <= boot_quad ? 3'h1 : 3'h7;
                rd_addr_q <= {boot_cfg_q[`SFL_BC_SA_HI:`SFL_BC_SA_LO], `SFL_BC_SA_PAD} +
                             32'h00000001;
            end
        end else if (sck_rise && state_q == S_ADDR && bits_q == `SFL_BITS_WORD - 6'h01) begin
            rd_addr_q <= addr_next & `SFL_ECC_MASK;
        end else if (tx_load) begin
            // Fresh byte, MSB first
            dq_out_q <= quad_q ? nb[7:4] : {2'b00, nb[7], 1'b0};
            dq_oe_n_q <= quad_q ? `SFL_OE_QUAD : `SFL_OE_SER;
            tx_sh_q <= quad_q ? {nb[3:0], 4'h0} : {nb[6:0], 1'b0};
            tx_cnt_q <= quad_q ? 3'h1 : 3'h7;
            rep_q <= rep_q + 4'h1;
            if (src_q == SRC_ECC && rep_q == `SFL_ECC_LAST) begin
                rd_addr_q <= rd_addr_q + `SFL_ECC_STEP;
            end else if (src_q == SRC_BOOT) begin
                rd_addr_q <= rd_addr_q + 32'h00000001;
            end
        end else if (tx_shift) begin
            dq_out_q <= quad_q ? tx_sh_q[7:4] : {2'b00, tx_sh_q[7], 1'b0};
            tx_sh_q <= quad_q ? {tx_sh_q[3:0], 4'h0} : {tx_sh_q[6:0], 1'b0};
            tx_cnt_q <= tx_cnt_q - 3'h1;
        end
    end

    // ***************************
    // Register and latch updates
    // ***************************
    wire len8 = (bits_q == `SFL_BITS_OPC);
    wire len16 = (bits_q == `SFL_BITS_BYTE);
    wire len40 = (bits_q == `SFL_BITS_WORD);
    wire exec = cs_rise & (src_q != SRC_BOOT);
    wire wr_ok = write_permit_latch_q & ~busy_flag_q;
    wire do_lset = exec & len8 & (opc_q == `SFL_OP_LATCH_SET);
    wire do_lclr = exec & len8 & (opc_q == `SFL_OP_LATCH_CLR) & ~busy_flag_q;
    wire do_fclr = exec & len8 & (opc_q == `SFL_OP_FLAG_CLR);
    wire do_bcwr = exec & len40 & (opc_q == `SFL_OP_BCFG_WR) & wr_ok;
    wire do_pnv = exec & len16 & (opc_q == `SFL_OP_PAT_NV) & wr_ok;
    wire do_pvol = exec & len16 & (opc_q == `SFL_OP_PAT_VOL) & wr_ok;
    wire [31:0] word_le = {sh_q[7:0], sh_q[15:8], sh_q[23:16], sh_q[31:24]};

    reg op_boot_q;
    reg [31:0] op_data_q;
    reg [15:0] op_cnt_q;
    wire op_done = op_run_q & (op_cnt_q == 16'h0001);

    // Self-timed nonvolatile write engine
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            op_run_q <= 1'b0;
            op_boot_q <= 1'b0;
            op_data_q <= 32'h00000000;
            op_cnt_q <= 16'h0000;
        end else if (do_bcwr || do_pnv) begin
            op_run_q <= 1'b1;
            op_boot_q <= do_bcwr;
            op_data_q <= do_bcwr ? word_le : {24'h000000, sh_q[7:0]};
            op_cnt_q <= NV_CYC;
        end else if (op_run_q) begin
            op_cnt_q <= op_cnt_q - 16'h0001;
            if (op_done) begin
                op_run_q <= 1'b0;
            end
        end
    end

    // Latch, flags and stored registers; hardware sets win over clears
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            write_permit_latch_q <= 1'b0;
            erase_fail_q <= 1'b0;
            program_fail_q <= 1'b0;
            boot_cfg_q <= BOOT_CFG_INIT;
            pattern_nv_register_q <= PATTERN_INIT;
            learning_pattern_q <= PATTERN_INIT;
        end else begin
            if (do_lset) begin
                write_permit_latch_q <= 1'b1;
            end else if (do_lclr || op_done) begin
                write_permit_latch_q <= 1'b0;
            end
            if (do_fclr) begin
                erase_fail_q <= 1'b0;
                program_fail_q <= 1'b0;
            end
            if (op_done) begin
                if (op_boot_q && nv_erase_fail) begin
                    erase_fail_q <= 1'b1;
                end
                if (nv_prog_fail) begin
                    program_fail_q <= 1'b1;
                end
                if (!nv_erase_fail && !nv_prog_fail) begin
                    if (op_boot_q) begin
                        boot_cfg_q <= op_data_q;
                    end else begin
                        pattern_nv_register_q <= op_data_q[7:0];
                    end
                end
            end
            // Volatile pattern is also the byte sent by the pattern read
            if (do_pvol) begin
                learning_pattern_q <= sh_q[7:0];
            end
        end
    end

    // Busy while writing or while a fail flag stands
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy_flag_q <= 1'b0;
        end else begin
            busy_flag_q <= (op_run_q & ~op_done) | do_bcwr | do_pnv |
                           ((erase_fail_q | program_fail_q) & ~do_fclr) |
                           (op_done & (nv_prog_fail | (op_boot_q & nv_erase_fail)));
        end
    end

    // Frames of any other length match no exec term above

endmodule // sfl_cmd
`default_nettype wire

/* File: sfl_cmd_assertions.sv */
// Concurrent checks on the latch, status and boot command block
`timescale 1ns/10ps
`default_nettype none
module sfl_cmd_assertions #(
    parameter NV_WRITE_CYCLES = 1000
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic quad_mode,
    input wire logic [3:0] read_latency,
    input wire logic [7:0] ecc_unit_status,
    input wire logic [7:0] rd_data,
    input wire logic nv_erase_fail,
    input wire logic nv_prog_fail,
    input wire logic [3:0] dq_out_q,
    input wire logic [3:0] dq_oe_n_q,
    input wire logic [31:0] rd_addr_q,
    input wire logic write_permit_latch_q,
    input wire logic busy_flag_q,
    input wire logic erase_fail_q,
    input wire logic program_fail_q,
    input wire logic [31:0] boot_cfg_q,
    input wire logic [7:0] learning_pattern_q
);
    localparam int BMAX = NV_WRITE_CYCLES + 8;
    wire fail_any;
    // Either sticky fail flag
    assign fail_any = erase_fail_q | program_fail_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Frame running with no self timed write around it
    sequence idle_s;
        (!cs_n)[*5] ##0 (!busy_flag_q && !$past(busy_flag_q) && !$past(busy_flag_q, 2));
    endsequence
    // Write ended without any failure standing
    property done_clean_p;
        $fell(busy_flag_q) && !$past(fail_any) && !$past(fail_any, 2) |-> !write_permit_latch_q;
    endproperty
    chk_fail_busy: assert property ((erase_fail_q || program_fail_q) |-> busy_flag_q)
        else $error("fail flag set while not busy");
    chk_busy_from_cs: assert property ($rose(busy_flag_q) |-> cs_n && $past(cs_n, 2))
        else $error("busy rose without chip select high");
    chk_busy_min: assert property ($rose(busy_flag_q) |-> busy_flag_q[*8])
        else $error("self timed write too short");
    chk_busy_bound: assert property ($rose(busy_flag_q) |-> ##[1:BMAX] (!busy_flag_q || fail_any))
        else $error("self timed write never ended");
    chk_done_latch: assert property (done_clean_p)
        else $error("latch still set after write");
    chk_latch_quiet: assert property (idle_s |-> $stable(write_permit_latch_q))
        else $error("latch changed inside a frame");
    chk_cfg_quiet: assert property (idle_s |-> $stable(boot_cfg_q))
        else $error("boot config changed inside a frame");
    chk_pattern_quiet: assert property ((!cs_n)[*5] |-> $stable(learning_pattern_q))
        else $error("pattern changed inside a frame");
    chk_oe_release: assert property (cs_n[*6] |-> dq_oe_n_q == 4'hf)
        else $error("lanes driven while deselected");
    chk_quad_lanes: assert property (dq_oe_n_q == 4'h0 |-> quad_mode)
        else $error("quad lanes driven without quad mode");
    cover property ($rose(busy_flag_q));
    cover property (dq_oe_n_q == 4'h0);
    cover property ($fell(write_permit_latch_q));
endmodule // sfl_cmd_assertions
bind sfl_cmd sfl_cmd_assertions #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) sfl_cmd_assertions_i (
    .core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .quad_mode(quad_mode),
    .read_latency(read_latency), .ecc_unit_status(ecc_unit_status), .rd_data(rd_data),
    .nv_erase_fail(nv_erase_fail), .nv_prog_fail(nv_prog_fail), .dq_out_q(dq_out_q),
    .dq_oe_n_q(dq_oe_n_q), .rd_addr_q(rd_addr_q), .write_permit_latch_q(write_permit_latch_q),
    .busy_flag_q(busy_flag_q), .erase_fail_q(erase_fail_q), .program_fail_q(program_fail_q),
    .boot_cfg_q(boot_cfg_q), .learning_pattern_q(learning_pattern_q));
`default_nettype wire

/* File: sfl_host.sv */
// Host controller model driving the serial pins in clock mode 0
`timescale 1ns/10ps
`default_nettype none
module sfl_host (
    input wire logic core_clk,
    output var logic cs_n,
    output var logic sck,
    output var logic si,
    input wire logic [3:0] dq_out_q,
    input wire logic [3:0] dq_oe_n_q
);
    logic [63:0] rx = 64'h0;
    logic [63:0] rxq = 64'h0;
    wire [3:0] lane;
    // Released lanes read back as the inverse of the last value
    assign lane = dq_out_q ^ dq_oe_n_q;
    // Idle pins at time zero, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // One frame: tx is left aligned, sampled data collects at each rise
    task automatic xfer(input logic [63:0] tx, input int nbits);
        int i;
        @(posedge core_clk) cs_n <= 1'b0;
        // Mode 0: data changes with the falling clock edge
        for (i = 0; i < nbits; i++) begin
            @(posedge core_clk) begin
                sck <= 1'b0;
                si <= (i < 64) ? tx[63 - i] : 1'b0;
            end
            repeat (3) @(posedge core_clk);
            // 80 ns clock keeps boot reads slow
            @(posedge core_clk) begin
                sck <= 1'b1;
                rx <= {rx[62:0], lane[1]};
                rxq <= {rxq[59:0], lane};
            end
            repeat (3) @(posedge core_clk);
        end
        @(posedge core_clk) sck <= 1'b0;
        repeat (3) @(posedge core_clk);
        // Select rises right after the chosen bit count
        cs_n <= 1'b1;
        si <= ~si;
        repeat (8) @(posedge core_clk);
        #1;
    endtask
endmodule // sfl_host
`default_nettype wire

/* File: sfl_cmd_tb.sv */
// Self-checking bench for the latch, status and boot command block
`timescale 1ns/10ps
`default_nettype none
module sfl_cmd_tb;
    localparam int NV = 32;
    localparam logic [31:0] BC_INIT = 32'h00000205; // enable, delay 2, start 200h
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic quad_mode = 1'b0;
    logic [3:0] read_latency = 4'h0;
    logic [7:0] ecc_unit_status = 8'h00;
    logic [7:0] rd_data = 8'h00;
    logic nv_erase_fail = 1'b0;
    logic nv_prog_fail = 1'b0;
    wire cs_n, sck, si, write_permit_latch_q, busy_flag_q, erase_fail_q, program_fail_q;
    wire [3:0] dq_out_q, dq_oe_n_q;
    wire [31:0] rd_addr_q, boot_cfg_q;
    wire [7:0] learning_pattern_q;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    sfl_cmd #(.NV_WRITE_CYCLES(NV), .BOOT_CFG_INIT(BC_INIT), .PATTERN_INIT(8'h96)) sfl_cmd_i (
        .core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .quad_mode(quad_mode),
        .read_latency(read_latency), .ecc_unit_status(ecc_unit_status), .rd_data(rd_data),
        .nv_erase_fail(nv_erase_fail), .nv_prog_fail(nv_prog_fail), .dq_out_q(dq_out_q),
        .dq_oe_n_q(dq_oe_n_q), .rd_addr_q(rd_addr_q), .write_permit_latch_q(write_permit_latch_q),
        .busy_flag_q(busy_flag_q), .erase_fail_q(erase_fail_q), .program_fail_q(program_fail_q),
        .boot_cfg_q(boot_cfg_q), .learning_pattern_q(learning_pattern_q));
    sfl_host sfl_host_i (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si),
        .dq_out_q(dq_out_q), .dq_oe_n_q(dq_oe_n_q));
    // 100 MHz clock
    always #5 core_clk = ~core_clk;
    // Array and ECC sources follow the requested address
    always @(posedge core_clk) begin
        rd_data <= rd_addr_q[7:0] ^ 8'ha5;
        ecc_unit_status <= rd_addr_q[11:4] ^ 8'h3c;
    end
    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int nbits);
        sfl_host_i.xfer({op, d, 48'h0}, nbits);
    endtask
    task automatic wait_idle;
        int n;
        for (n = 0; n < NV + 20 && busy_flag_q !== 1'b0; n++) @(posedge core_clk);
        #1;
    endtask
    task automatic do_reset;
        nrst <= 1'b0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_boot;
        sfl_host_i.xfer(64'h0, 18);
        check(sfl_host_i.rx[15:0], 16'ha5a4);
        cmd(8'h41, 8'h00, 24);
        check(sfl_host_i.rx[15:0], 16'h9696);
        $display("test_boot done");
    endtask
    task automatic test_latch;
        cmd(8'h06, 8'h00, 7);
        check(write_permit_latch_q, 1'b0);
        cmd(8'h06, 8'h00, 8);
        check(write_permit_latch_q, 1'b1);
        cmd(8'h04, 8'h00, 9);
        check(write_permit_latch_q, 1'b1);
        cmd(8'h04, 8'h00, 8);
        check(write_permit_latch_q, 1'b0);
        $display("test_latch done");
    endtask
    task automatic test_pattern;
        cmd(8'h4a, 8'h3c, 16);
        check(learning_pattern_q, 8'h96);
        cmd(8'h06, 8'h00, 8);
        cmd(8'h4a, 8'h3c, 16);
        check({busy_flag_q, learning_pattern_q}, {1'b0, 8'h3c});
        cmd(8'h41, 8'h00, 16);
        check(sfl_host_i.rx[7:0], 8'h3c);
        nv_prog_fail <= 1'b1;
        cmd(8'h06, 8'h00, 8);
        cmd(8'h43, 8'hc3, 16);
        check(busy_flag_q, 1'b1);
        repeat (NV + 4) @(posedge core_clk);
        #1;
        check({program_fail_q, busy_flag_q, write_permit_latch_q}, 3'b110);
        nv_prog_fail <= 1'b0;
        cmd(8'h06, 8'h00, 8);
        cmd(8'h04, 8'h00, 8);
        check(write_permit_latch_q, 1'b1);
        cmd(8'h30, 8'h00, 8);
        check({erase_fail_q, program_fail_q, busy_flag_q, write_permit_latch_q}, 4'h1);
        $display("test_pattern done");
    endtask
    task automatic test_bootcfg;
        cmd(8'h14, 8'h00, 72);
        check(sfl_host_i.rx, 64'h0502000005020000);
        cmd(8'h06, 8'h00, 8);
        sfl_host_i.xfer({8'h15, 32'h015e3412, 24'h0}, 39);
        wait_idle();
        check({boot_cfg_q, write_permit_latch_q}, {BC_INIT, 1'b1});
        sfl_host_i.xfer({8'h15, 32'h015e3412, 24'h0}, 40);
        check(busy_flag_q, 1'b1);
        wait_idle();
        check({boot_cfg_q, write_permit_latch_q}, {32'h12345e01, 1'b0});
        nv_erase_fail <= 1'b1;
        cmd(8'h06, 8'h00, 8);
        sfl_host_i.xfer({8'h15, 32'hffffffff, 24'h0}, 40);
        repeat (NV + 4) @(posedge core_clk);
        #1;
        check({erase_fail_q, write_permit_latch_q, boot_cfg_q}, {2'b10, 32'h12345e01});
        nv_erase_fail <= 1'b0;
        cmd(8'h30, 8'h00, 8);
        check({erase_fail_q, busy_flag_q}, 2'b00);
        $display("test_bootcfg done");
    endtask
    task automatic test_ecc;
        read_latency <= 4'h2;
        sfl_host_i.xfer({8'h18, 32'h00000120, 24'h0}, 178);
        check(sfl_host_i.rx, 64'h2e2e2e2e2e2e2e2f);
        $display("test_ecc done");
    endtask
    task automatic test_quad;
        quad_mode <= 1'b1;
        do_reset();
        sfl_host_i.xfer(64'h0, 6);
        check(sfl_host_i.rxq[15:0], 16'ha5a4);
        $display("test_quad done");
    endtask
    // Main sequence
    initial begin
        do_reset();
        test_boot();
        test_latch();
        test_pattern();
        test_bootcfg();
        test_ecc();
        test_quad();
        finish_test();
    end
endmodule // sfl_cmd_tb
`default_nettype wire
